// ### src/sgc_justify.sv
// Result formatter: packs a conversion result into the high and low data bytes
`timescale 1ns/10ps
`default_nettype none
module sgc_justify
   import sgc_pkg::*;
(
   // Conversion result and mode
   input  wire logic [RES_W_MAIN-1:0] result,
   input  wire logic                  alt_variant,
   input  wire logic                  differential,
   input  wire logic                  left_justify,
   // Packed bytes
   output logic      [7:0]            high_byte,
   output logic      [7:0]            low_byte
);
   // -----------------------------------------------------------------
   // Alignment
   // -----------------------------------------------------------------
   // Narrow result lives in the low bits; its sign is its own top bit
   wire logic        sign_main = result[RES_W_MAIN-1];
   wire logic        sign_alt  = result[RES_W_ALT-1];
   wire logic        sign_bit  = differential & (alt_variant ? sign_alt : sign_main);
   wire logic [15:0] right_main = {{4{sign_bit}}, result};                          // RQ11 RQ12
   wire logic [15:0] right_alt  = {{6{sign_bit}}, result[RES_W_ALT-1:0]};           // RQ15
   wire logic [15:0] left_main  = {result, 4'h0};                                   // RQ13
   wire logic [15:0] left_alt   = {result[RES_W_ALT-1:0], 6'h00};                   // RQ15
   wire logic [15:0] right_word = alt_variant ? right_alt : right_main;
   wire logic [15:0] left_word  = alt_variant ? left_alt  : left_main;
   wire logic [15:0] word       = left_justify ? left_word : right_word;            // RQ17
   assign high_byte = word[15:8];
   assign low_byte  = word[7:0];
endmodule : sgc_justify
`default_nettype wire

// ### src/sgc_pkg.sv
// Package: register map, field layout and reset values of the converter control block
package sgc_pkg;
   // -----------------------------------------------------------------
   // Register addresses
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_PAIR_CFG  = 8'hBA;
   localparam logic [7:0] ADDR_CONV_CFG  = 8'hBC;
   localparam logic [7:0] ADDR_RES_LOW   = 8'hBE;
   localparam logic [7:0] ADDR_RES_HIGH  = 8'hBF;
   localparam logic [7:0] ADDR_CONV_CTL  = 8'hB7;
   localparam logic [7:0] ADDR_CHAN_SEL  = 8'hB6;
   // -----------------------------------------------------------------
   // Reset values and writable masks
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_PAIR_CFG   = 8'h00;
   localparam logic [7:0] RST_CONV_CFG   = 8'h60;
   localparam logic [7:0] RST_CONV_CTL   = 8'h00;
   localparam logic [7:0] RST_CHAN_SEL   = 8'h00;
   localparam logic [7:0] RST_RESULT     = 8'h00;
   localparam logic [7:0] MASK_PAIR_CFG  = 8'h0F;
   localparam logic [7:0] MASK_CONV_CFG  = 8'hE7;
   localparam logic [7:0] MASK_CONV_CTL  = 8'h81;
   localparam logic [7:0] MASK_CHAN_SEL  = 8'h0F;
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int CTL_ENABLE_BIT  = 7;
   localparam int CTL_LJUST_BIT   = 0;
   localparam int GAIN_LSB        = 0;
   localparam int GAIN_W          = 3;
   localparam int CLKDIV_LSB      = 5;
   localparam int CLKDIV_W        = 3;
   // -----------------------------------------------------------------
   // Channels and result widths
   // -----------------------------------------------------------------
   localparam int                NUM_PAIRS    = 4;
   localparam logic [3:0]        CHAN_TEMP    = 4'h8;
   localparam int                RES_W_MAIN   = 12;
   localparam int                RES_W_ALT    = 10;
   // One-hot gain outputs, bit order
   localparam int GSEL_HALF = 0;
   localparam int GSEL_1    = 1;
   localparam int GSEL_2    = 2;
   localparam int GSEL_4    = 3;
   localparam int GSEL_8    = 4;
   localparam int GSEL_16   = 5;
   localparam int GSEL_W    = 6;
endpackage : sgc_pkg

// ### src/sgc_top.sv
// Top: register file, multiplexer pairing, gain select, enable gating and result capture
`timescale 1ns/10ps
`default_nettype none
// How it works
// RQ1: Analog blocks powered only while enable set
// RQ2: Software sets bias enable before converting
// RQ3: Nine channels, ninth is temperature sensor
// RQ4: Gain applies equally to temperature channel
// RQ5: Four pair bits select single or differential
// RQ6: Pair configuration clears to zero on reset
// RQ7: Upper four pair bits read zero
// RQ8: Pairing changes accepted while running
// RQ9: Gains 0.5 to 16 via three-bit field
// RQ10: Gain defaults to one after reset
// RQ11: Differential results are two's complement
// RQ12: Right justify: sign or zero top nibble
// RQ13: Left justify: low nibble reads zero
// RQ14: Main variant gives 12-bit results
// RQ15: Alternative variant gives 10-bit results
// RQ16: Gain field encoding per documented table
// RQ17: Justify bit: one left, zero right
// RQ18: Both data bytes update together
module sgc_top
   import sgc_pkg::*;
#(
   parameter bit ALT_VARIANT = 1'b0
)(
   // Clock, reset, enable
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic                  ce,
   // Special function register port
   input  wire logic [7:0]            sfr_addr,
   input  wire logic                  sfr_wr,
   input  wire logic                  sfr_rd,
   input  wire logic [7:0]            sfr_wdata,
   output logic      [7:0]            sfr_rdata,
   // Reference bias level from the reference block
   input  wire logic                  bias_enable,
   // Analog core handshake
   input  wire logic                  conv_done,
   input  wire logic [RES_W_MAIN-1:0] conv_result,
   // Analog control outputs
   output logic                       converter_power,
   output logic                       track_hold_power,
   output logic                       gain_stage_power,
   output logic                       bias_supply,
   output logic      [GSEL_W-1:0]     gain_select,
   output logic      [2:0]            mux_pos_sel,
   output logic      [2:0]            mux_neg_sel,
   output logic                       mux_neg_ground,
   output logic                       temp_sensor_sel,
   output logic      [CLKDIV_W-1:0]   sar_clock_div
);
   // -----------------------------------------------------------------
   // Reset release
   // -----------------------------------------------------------------
   logic [1:0] rst_sync_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) rst_sync_q <= 2'b00;
      else       rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   wire logic rst_n = rst_sync_q[1];

   // -----------------------------------------------------------------
   // Decoding
   // -----------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      hit = (a == target);
   endfunction

   // Gain field to one-hot stage select
   function automatic logic [GSEL_W-1:0] gain_decode(input logic [GAIN_W-1:0] g);
      logic [GSEL_W-1:0] s;
      s = '0;
      case (g)
         3'h0:       s[GSEL_1]    = 1'b1;
         3'h1:       s[GSEL_2]    = 1'b1;
         3'h2:       s[GSEL_4]    = 1'b1;
         3'h3:       s[GSEL_8]    = 1'b1;
         3'h4, 3'h5: s[GSEL_16]   = 1'b1;
         default:    s[GSEL_HALF] = 1'b1;
      endcase
      gain_decode = s;
   endfunction

   logic [7:0] pair_cfg_q;
   logic [7:0] conv_cfg_q;
   logic [7:0] conv_ctl_q;
   logic [7:0] chan_sel_q;
   logic [7:0] res_low_q;
   logic [7:0] res_high_q;
   logic [7:0] rdata_q;

   // -----------------------------------------------------------------
   // Write strobes
   // -----------------------------------------------------------------
   wire logic wr_pair  = sfr_wr & hit(sfr_addr, ADDR_PAIR_CFG);
   wire logic wr_cfg   = sfr_wr & hit(sfr_addr, ADDR_CONV_CFG);
   wire logic wr_ctl   = sfr_wr & hit(sfr_addr, ADDR_CONV_CTL);
   wire logic wr_chan  = sfr_wr & hit(sfr_addr, ADDR_CHAN_SEL);
   wire logic wr_low   = sfr_wr & hit(sfr_addr, ADDR_RES_LOW);
   wire logic wr_high  = sfr_wr & hit(sfr_addr, ADDR_RES_HIGH);


   // -----------------------------------------------------------------
   // Register fields
   // -----------------------------------------------------------------
   wire logic enabled  = conv_ctl_q[CTL_ENABLE_BIT];
   wire logic ljust    = conv_ctl_q[CTL_LJUST_BIT];
   wire logic [3:0] chan = chan_sel_q[3:0];

   // -----------------------------------------------------------------
   // Multiplexer pairing
   // -----------------------------------------------------------------
   // Per-pair differential flags, one per even/odd input pair
   logic [NUM_PAIRS-1:0] pair_diff;
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PAIRS; gp++) begin : g_pair
         assign pair_diff[gp] = pair_cfg_q[gp];                                     // RQ5
      end
   endgenerate

   // Codes above the temperature channel also pick the sensor
   wire logic is_temp   = (chan >= CHAN_TEMP);                                      // RQ3
   wire logic diff_chan = ~is_temp & pair_diff[chan[2:1]];                          // RQ5 RQ8

   // -----------------------------------------------------------------
   // Result packing
   // -----------------------------------------------------------------
   logic [7:0] pack_high;
   logic [7:0] pack_low;
   sgc_justify u_justify (
      .result       (conv_result),
      .alt_variant  (ALT_VARIANT),                                                  // RQ14 RQ15
      .differential (diff_chan),
      .left_justify (ljust),
      .high_byte    (pack_high),
      .low_byte     (pack_low)
   );

   // A done pulse while shut down is dropped: no core is running
   wire logic capture = conv_done & enabled;                                        // RQ1

   // -----------------------------------------------------------------
   // Register file
   // -----------------------------------------------------------------
   // Reserved bits are masked on the way in, so they always read zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)            pair_cfg_q <= RST_PAIR_CFG;                            // RQ6
      else if (ce & wr_pair) pair_cfg_q <= sfr_wdata & MASK_PAIR_CFG;               // RQ7 RQ8
   end

   // Gain and conversion clock divide share one register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)            conv_cfg_q <= RST_CONV_CFG;                            // RQ10
      else if (ce & wr_cfg)  conv_cfg_q <= sfr_wdata & MASK_CONV_CFG;               // RQ9
   end

   // Enable and justify bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)            conv_ctl_q <= RST_CONV_CTL;
      else if (ce & wr_ctl)  conv_ctl_q <= sfr_wdata & MASK_CONV_CTL;               // RQ17
   end

   // Channel code; codes above the sensor are kept, not clipped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)            chan_sel_q <= RST_CHAN_SEL;
      else if (ce & wr_chan) chan_sel_q <= sfr_wdata & MASK_CHAN_SEL;
   end

   // Capture beats a same-cycle software write so no result is lost
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         res_low_q  <= RST_RESULT;
         res_high_q <= RST_RESULT;
      end else if (ce) begin
         if (capture) begin
            res_low_q  <= pack_low;                                                 // RQ18
            res_high_q <= pack_high;                                                // RQ18
         end else begin
            if (wr_low)  res_low_q  <= sfr_wdata;
            if (wr_high) res_high_q <= sfr_wdata;
         end
      end
   end

   // -----------------------------------------------------------------
   // Read port
   // -----------------------------------------------------------------
   wire logic [7:0] rd_mux =
      hit(sfr_addr, ADDR_PAIR_CFG) ? pair_cfg_q :                                  // RQ7
      hit(sfr_addr, ADDR_CONV_CFG) ? conv_cfg_q :
      hit(sfr_addr, ADDR_CONV_CTL) ? conv_ctl_q :
      hit(sfr_addr, ADDR_CHAN_SEL) ? chan_sel_q :
      hit(sfr_addr, ADDR_RES_LOW)  ? res_low_q  :
      hit(sfr_addr, ADDR_RES_HIGH) ? res_high_q : 8'h00;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)          rdata_q <= 8'h00;
      else if (ce & sfr_rd) rdata_q <= rd_mux;
   end
   assign sfr_rdata = rdata_q;

   // -----------------------------------------------------------------
   // Analog controls
   // -----------------------------------------------------------------
   assign converter_power  = enabled;                                               // RQ1
   assign track_hold_power = enabled;                                               // RQ1
   assign gain_stage_power = enabled;                                               // RQ1

   // -----------------------------------------------------------------
   // Bias gating
   // -----------------------------------------------------------------
   // Bias is owned by the reference block; passed on only to a live core
   assign bias_supply      = enabled & bias_enable;                                 // RQ2

   // -----------------------------------------------------------------
   // Gain and routing
   // -----------------------------------------------------------------
   // Same decode for every channel, temperature sensor included
   assign gain_select      = gain_decode(conv_cfg_q[GAIN_LSB +: GAIN_W]);           // RQ4 RQ16
   assign mux_pos_sel      = diff_chan ? {chan[2:1], 1'b0} : chan[2:0];             // RQ5
   assign mux_neg_sel      = diff_chan ? {chan[2:1], 1'b1} : 3'h0;                  // RQ5
   assign mux_neg_ground   = ~diff_chan;
   assign temp_sensor_sel  = is_temp;                                               // RQ3
   assign sar_clock_div    = conv_cfg_q[CLKDIV_LSB +: CLKDIV_W];
endmodule : sgc_top
`default_nettype wire

// ### verif/sgc_top_monitor.sv
// Checker: port-level properties of the converter control block
`timescale 1ns/10ps
`default_nettype none
module sgc_top_monitor
   import sgc_pkg::*;
(
   // Clock, reset, enable
   input wire logic              clk,
   input wire logic              nrst,
   input wire logic              ce,
   // Register port
   input wire logic [7:0]        sfr_addr,
   input wire logic              sfr_wr,
   input wire logic              sfr_rd,
   input wire logic [7:0]        sfr_wdata,
   input wire logic [7:0]        sfr_rdata,
   // Analog control
   input wire logic              bias_enable,
   input wire logic              converter_power,
   input wire logic              track_hold_power,
   input wire logic              gain_stage_power,
   input wire logic              bias_supply,
   input wire logic [GSEL_W-1:0] gain_select,
   input wire logic [2:0]        mux_pos_sel,
   input wire logic [2:0]        mux_neg_sel,
   input wire logic              mux_neg_ground,
   input wire logic              temp_sensor_sel
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   function automatic int gidx(logic [2:0] g);
      return g[2] ? (g[1] ? GSEL_HALF : GSEL_16) : GSEL_1 + int'(g[1:0]);
   endfunction
   // -----------------------------------------------------------------
   // Properties
   // -----------------------------------------------------------------
   chk_power_follows_en: assert property ((ce && sfr_wr && sfr_addr == ADDR_CONV_CTL) |=>
      {3{$past(sfr_wdata[CTL_ENABLE_BIT])}} == {converter_power, track_hold_power, gain_stage_power})
      else $error("analog power does not follow enable bit");
   chk_bias_gated: assert property (bias_supply == (converter_power && bias_enable))
      else $error("bias supply not gated by enable");
   chk_gain_decode: assert property ((ce && sfr_wr && sfr_addr == ADDR_CONV_CFG) |=>
      gain_select == (6'h01 << gidx($past(sfr_wdata[2:0]))))
      else $error("gain select does not match gain field");
   chk_gain_default: assert property ($rose(nrst) |-> gain_select == 6'h02)
      else $error("gain not unity after reset");
   chk_pair_upper: assert property ((ce && sfr_rd && sfr_addr == ADDR_PAIR_CFG) |=>
      sfr_rdata[7:4] == 4'h0)
      else $error("pair config upper bits not zero");
   chk_rdata_hold: assert property (!(ce && sfr_rd) |=> $stable(sfr_rdata))
      else $error("read data changed without a read");
   chk_temp_select: assert property ((ce && sfr_wr && sfr_addr == ADDR_CHAN_SEL) |=>
      temp_sensor_sel == ($past(sfr_wdata[3:0]) >= CHAN_TEMP))
      else $error("temperature channel select wrong");
   chk_diff_routing: assert property (mux_neg_ground ? (mux_neg_sel == 3'h0) :
      (!mux_pos_sel[0] && mux_neg_sel == mux_pos_sel + 3'h1))
      else $error("differential routing not even plus odd minus");
endmodule // sgc_top_monitor
bind sgc_top sgc_top_monitor mon_u (.clk(clk), .nrst(nrst), .ce(ce), .sfr_addr(sfr_addr),
   .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
   .bias_enable(bias_enable), .converter_power(converter_power),
   .track_hold_power(track_hold_power), .gain_stage_power(gain_stage_power),
   .bias_supply(bias_supply), .gain_select(gain_select), .mux_pos_sel(mux_pos_sel),
   .mux_neg_sel(mux_neg_sel), .mux_neg_ground(mux_neg_ground),
   .temp_sensor_sel(temp_sensor_sel));
`default_nettype wire

// ### verif/tb_top.sv
// Testbench: register access, gain decode, enable gating and result formatting
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import sgc_pkg::*;
;
   logic              clk = 1'b0, nrst = 1'b0, ce = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic [7:0]        sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, exp_q[$];
   logic              bias_enable = 1'b0, conv_done = 1'b0, rd_seen = 1'b0;
   logic [11:0]       conv_result = 12'h000;
   logic              cpw, thp, gsp, bias_supply, mux_neg_ground, temp_sensor_sel;
   logic [GSEL_W-1:0] gain_select;
   logic [2:0]        mux_pos_sel, mux_neg_sel, sar_clock_div;
   int                mismatches = 0, n_compared = 0, seed = 8253;
   always #10 clk = ~clk;
   sgc_top dut_u (.clk(clk), .nrst(nrst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bias_enable(bias_enable),
      .conv_done(conv_done), .conv_result(conv_result), .converter_power(cpw),
      .track_hold_power(thp), .gain_stage_power(gsp), .bias_supply(bias_supply),
      .gain_select(gain_select), .mux_pos_sel(mux_pos_sel), .mux_neg_sel(mux_neg_sel),
      .mux_neg_ground(mux_neg_ground), .temp_sensor_sel(temp_sensor_sel),
      .sar_clock_div(sar_clock_div));
   function automatic int gidx(logic [2:0] g);
      return g[2] ? (g[1] ? GSEL_HALF : GSEL_16) : GSEL_1 + int'(g[1:0]);
   endfunction
   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic bus(logic [7:0] a, logic [7:0] d, logic w);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= w;
      sfr_rd <= !w;
      @(posedge clk);
      sfr_wr <= 1'b0;
      sfr_rd <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      exp_q.push_back(e);
      bus(a, 8'h00, 1'b0);
   endtask
   task automatic conv(logic [11:0] r);
      @(posedge clk);
      conv_result <= r;
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      conv_result <= ~r;   // Result is only valid with the pulse
   endtask
   // Read data lands on the same edge that takes the read; it is checked on the next falling edge
   always @(posedge clk) rd_seen <= sfr_rd & ce;
   always @(negedge clk) begin
      if (rd_seen) begin
         check("sfr_rdata", {8'h00, exp_q.pop_front()}, {8'h00, sfr_rdata});
      end
   end
   initial begin
      #(20 * 20000);
      mismatches++;
      $display("ERROR watchdog expected done seen timeout");
      test_done();
   end
   // -----------------------------------------------------------------
   // Stimulus
   // -----------------------------------------------------------------
   initial begin
      logic [11:0] r;
      logic [3:0]  pc, ch;
      logic        lj, df;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check("gain_select", 16'(6'h02), 16'(gain_select));
      check("power", 16'h0, {13'h0, cpw, thp, gsp});
      check("sar_clock_div", 16'(RST_CONV_CFG[CLKDIV_LSB +: CLKDIV_W]), 16'(sar_clock_div));
      rd(ADDR_PAIR_CFG, 8'h00);
      rd(ADDR_CONV_CFG, 8'h60);
      rd(8'hB5, 8'h00);
      bus(ADDR_PAIR_CFG, 8'hFF, 1'b1);
      rd(ADDR_PAIR_CFG, 8'h0F);
      ce <= 1'b0;
      bus(ADDR_PAIR_CFG, 8'h05, 1'b1);
      ce <= 1'b1;
      rd(ADDR_PAIR_CFG, 8'h0F);
      for (int g = 0; g < 8; g++) begin
         bus(ADDR_CONV_CFG, {5'b01100, 3'(g)}, 1'b1);
         #1;
         check("gain_select", 16'h1 << gidx(3'(g)), 16'(gain_select));
      end
      conv(12'hABC);
      rd(ADDR_RES_LOW, 8'h00);
      repeat (24) begin
         r = 12'($random(seed));
         pc = 4'($random(seed));
         ch = 4'($unsigned($random(seed)) % 9);
         lj = 1'($random(seed));
         df = (ch < 4'h8) && pc[ch[2:1]];
         bias_enable <= 1'($random(seed));
         bus(ADDR_PAIR_CFG, {4'h0, pc}, 1'b1);
         bus(ADDR_CHAN_SEL, {4'h0, ch}, 1'b1);
         bus(ADDR_CONV_CTL, {7'h40, lj}, 1'b1);
         conv(~r);
         conv(r);
         #1;
         check("power", 16'h7, {13'h0, cpw, thp, gsp});
         check("bias_supply", {15'h0, bias_enable}, {15'h0, bias_supply});
         check("temp_sensor_sel", {15'h0, ch[3]}, {15'h0, temp_sensor_sel});
         check("mux_neg_ground", {15'h0, !df}, {15'h0, mux_neg_ground});
         check("mux_pos_sel", 16'(df ? {ch[2:1], 1'b0} : ch[2:0]), 16'(mux_pos_sel));
         check("mux_neg_sel", 16'(df ? {ch[2:1], 1'b1} : 3'h0), 16'(mux_neg_sel));
         rd(ADDR_RES_HIGH, lj ? r[11:4] : {{4{df & r[11]}}, r[11:8]});
         rd(ADDR_RES_LOW, lj ? {r[3:0], 4'h0} : r[7:0]);
      end
      bus(ADDR_CONV_CTL, 8'h00, 1'b1);
      #1;
      check("power", 16'h0, {13'h0, cpw, thp, gsp});
      repeat (2) @(posedge clk);
      test_done();
   end
endmodule // tb_top
`default_nettype wire
